// *** design/rusw_map.svh ***
// Constants of the upgrade status and watchdog block.
// Assumes inclusion by the package, the watchdog and the top module.
`ifndef RUSW_MAP_SVH
`define RUSW_MAP_SVH

// ------------------------------------------------------------
// Control and update register layout
// ------------------------------------------------------------
`define RUSW_CTL_W        39
`define RUSW_CTL_EARLY    37
`define RUSW_CTL_OSC_INT  36
`define RUSW_CTL_WATCHDOG_ENABLE_BIT    35
`define RUSW_CTL_ADDR_HI  33
`define RUSW_CTL_ADDR_LO  12
`define RUSW_CTL_TMR_HI   11
`define RUSW_CTL_TMR_LO   0
`define RUSW_CTL_RESET    39'h00_0000_0000

// ------------------------------------------------------------
// Status views and previous-state records
// ------------------------------------------------------------
`define RUSW_STAT_W       32
`define RUSW_PREV_W       31
`define RUSW_SRC_HI       30
`define RUSW_SRC_LO       26
`define RUSW_PREV_MS_HI   25
`define RUSW_PREV_MS_LO   24
`define RUSW_BOOT_W       24
`define RUSW_PREV_RESET   31'h0000_0000
`define RUSW_INVALID_CAP  39'h7F_FFFF_FFFF

// Source one-hot positions within the five-bit source field
`define RUSW_SRC_EXT      4
`define RUSW_SRC_CRC      3
`define RUSW_SRC_PIN      2
`define RUSW_SRC_WD       1
`define RUSW_SRC_FAB      0

// Master state field codes
`define RUSW_MS_FACTORY   2'h0
`define RUSW_MS_APP_LOAD  2'h1
`define RUSW_MS_APP_USER  2'h3

// Capture selections
`define RUSW_CAP_VIEW_A   2'h0
`define RUSW_CAP_VIEW_B   2'h1
`define RUSW_CAP_PREV1    2'h2
`define RUSW_CAP_PREV2    2'h3

// ------------------------------------------------------------
// Watchdog and timing
// ------------------------------------------------------------
`define RUSW_WD_W         29
`define RUSW_WD_LOW       17'h00008
`define RUSW_CLK_NS       50
`define RUSW_MIN_PULSE_NS 250
`define RUSW_MIN_PULSE_CYC \
  ((`RUSW_MIN_PULSE_NS + `RUSW_CLK_NS - 1) / `RUSW_CLK_NS)

`endif

// *** design/rusw_pkg.sv ***
// Types of the upgrade status and watchdog block.
// Assumes the constants header is on the include path.
`include "rusw_map.svh"

package rusw_pkg;

  typedef logic [`RUSW_CTL_W-1:0] rusw_ctl_t;

  typedef enum logic [2:0] {
    RUSW_ST_FACTORY  = 3'b001,
    RUSW_ST_APP_LOAD = 3'b010,
    RUSW_ST_APP_USER = 3'b100
  } rusw_state_e;

endpackage

// *** design/rusw_sync.sv ***
// Two-flop level synchroniser, one per bit.
// Assumes asynchronous inputs from user fabric logic.
`timescale 1ns/1ns

module rusw_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// *** design/rusw_watchdog.sv ***
// User watchdog down-counter.
// Assumes enable and reload come from the synchronous control logic.
`timescale 1ns/1ns
`include "rusw_map.svh"

module rusw_watchdog #(
  parameter int CNT_W = `RUSW_WD_W
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  input  wire logic             reload_i,
  input  wire logic [CNT_W-1:0] load_value_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expire_o
);

  // Held at the load value while disabled, counts only when enabled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (!enable_i || reload_i) begin
      count_o <= load_value_i;
    end else if (count_o != '0) begin
      count_o <= count_o - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= enable_i && !reload_i && (count_o == CNT_W'(1));
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_wd_reload;
    enable_i && reload_i |=> count_o == $past(load_value_i);
  endproperty
  a_wd_reload: assert property (p_wd_reload)
    else $error("watchdog reload did not restore timeout");

  property p_wd_count;
    enable_i && !reload_i && count_o > CNT_W'(1)
      |=> count_o == $past(count_o) - CNT_W'(1);
  endproperty
  a_wd_count: assert property (p_wd_count)
    else $error("watchdog did not count down by one");

endmodule

// *** design/rusw_top.sv ***
// Remote upgrade status recorder, control loader and user watchdog.
// Assumes synchronous trigger inputs, except the two fabric strobes.
`timescale 1ns/1ns
`include "rusw_map.svh"

module rusw_top #(
  parameter int QUAL_W = 4
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Configuration triggers
  input  wire logic                    external_config_reset_i,
  input  wire logic                    config_error_pin_n_i,
  input  wire logic                    crc_error_i,
  input  wire logic                    app_user_mode_i,
  // Fabric strobes, asynchronous
  input  wire logic                    fabric_reconfig_request_i,
  input  wire logic                    watchdog_reload_strobe_i,
  // Shift register access
  input  wire logic                    shift_en_i,
  input  wire logic                    shift_data_i,
  input  wire logic                    capture_i,
  input  wire logic                    update_i,
  input  wire logic [1:0]              capture_sel_i,
  output logic                         shift_data_o,
  // Configuration outputs
  output logic                         reconfig_start_o,
  output logic [`RUSW_BOOT_W-1:0]      boot_address_o,
  output logic [1:0]                   master_state_o,
  output logic                         watchdog_timeout_o,
  output rusw_pkg::rusw_ctl_t          control_word_o
);

  import rusw_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam logic [QUAL_W-1:0] QUAL_MAX = QUAL_W'(`RUSW_MIN_PULSE_CYC);

  rusw_state_e                state_reg;
  rusw_ctl_t                  ctl_reg;
  rusw_ctl_t                  upd_reg;
  rusw_ctl_t                  shift_reg;
  rusw_ctl_t                  cap_next;
  logic [`RUSW_BOOT_W-1:0]    boot_reg;
  logic [`RUSW_PREV_W-1:0]    prev1_reg;
  logic [`RUSW_PREV_W-1:0]    prev2_reg;
  logic                       app_seen_reg;
  logic [1:0]                 strobe_sync;
  logic [1:0]                 strobe_qual;
  logic [4:0]                 src_raw;
  logic [4:0]                 src_oh;
  logic                       trigger;
  logic                       fab_win;
  logic [1:0]                 ms_code;
  logic [`RUSW_WD_W-1:0]      wd_load;
  logic [`RUSW_WD_W-1:0]      wd_count;
  logic                       wd_enable;
  logic                       wd_expire;
  logic [`RUSW_STAT_W-1:0]    view_fac;
  logic [`RUSW_STAT_W-1:0]    view_app1;
  logic [`RUSW_STAT_W-1:0]    view_app2;

  // ------------------------------------------------------------
  // Fabric strobe synchronisation and pulse qualification
  // ------------------------------------------------------------
  rusw_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   ({watchdog_reload_strobe_i, fabric_reconfig_request_i}),
    .sync_o    (strobe_sync)
  );

  // Act once per strobe, after it has stood the least pulse time
  for (genvar ch = 0; ch < 2; ch++) begin : g_qual
    logic [QUAL_W-1:0] cnt_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_reg <= '0;
      end else if (!strobe_sync[ch]) begin
        cnt_reg <= '0;
      end else if (cnt_reg != QUAL_MAX) begin
        cnt_reg <= cnt_reg + QUAL_W'(1);
      end
    end

    assign strobe_qual[ch] = strobe_sync[ch]
                             && (cnt_reg == QUAL_MAX - QUAL_W'(1));
  end

  // ------------------------------------------------------------
  // Trigger sources and priority
  // ------------------------------------------------------------
  always_comb begin
    src_raw                = 5'h00;
    src_raw[`RUSW_SRC_EXT] = external_config_reset_i;
    src_raw[`RUSW_SRC_CRC] = crc_error_i
                             && (state_reg == RUSW_ST_APP_LOAD);
    src_raw[`RUSW_SRC_PIN] = !config_error_pin_n_i;
    src_raw[`RUSW_SRC_WD]  = wd_expire;
    src_raw[`RUSW_SRC_FAB] = strobe_qual[0]
                             && (state_reg == RUSW_ST_FACTORY);
  end

  // Highest-numbered source alone survives
  always_comb begin
    src_oh = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (src_raw[i]) begin
        src_oh = 5'(5'h01 << i);
      end
    end
  end

  assign trigger = |src_raw;
  assign fab_win = src_oh[`RUSW_SRC_FAB];

  // Two-bit state code
  always_comb begin
    case (state_reg)
      RUSW_ST_FACTORY:  ms_code = `RUSW_MS_FACTORY;
      RUSW_ST_APP_LOAD: ms_code = `RUSW_MS_APP_LOAD;
      RUSW_ST_APP_USER: ms_code = `RUSW_MS_APP_USER;
      default:          ms_code = `RUSW_MS_FACTORY;
    endcase
  end

  // ------------------------------------------------------------
  // Master state machine
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= RUSW_ST_FACTORY;
    end else begin
      case (state_reg)
        RUSW_ST_FACTORY: begin
          if (fab_win) begin
            state_reg <= RUSW_ST_APP_LOAD;
          end
        end
        RUSW_ST_APP_LOAD: begin
          if (trigger) begin
            state_reg <= RUSW_ST_FACTORY;
          end else if (app_user_mode_i) begin
            state_reg <= RUSW_ST_APP_USER;
          end
        end
        RUSW_ST_APP_USER: begin
          if (trigger) begin
            state_reg <= RUSW_ST_FACTORY;
          end
        end
        default: begin
          state_reg <= RUSW_ST_FACTORY;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control, update and boot address registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= `RUSW_CTL_RESET;
    end else if (trigger) begin
      ctl_reg <= fab_win ? upd_reg : `RUSW_CTL_RESET;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      boot_reg <= '0;
    end else if (trigger) begin
      boot_reg <= fab_win
        ? {upd_reg[`RUSW_CTL_ADDR_HI:`RUSW_CTL_ADDR_LO], 2'b00}
        : '0;
    end
  end

  // Fabric writes reach the update register only under factory
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      upd_reg <= `RUSW_CTL_RESET;
    end else if (update_i && state_reg == RUSW_ST_FACTORY) begin
      upd_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reconfig_start_o <= 1'b0;
    end else begin
      reconfig_start_o <= trigger;
    end
  end

  // ------------------------------------------------------------
  // Previous-state records
  // ------------------------------------------------------------
  // Written in the trigger cycle, on the same edge as the reconfiguration start
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prev1_reg <= `RUSW_PREV_RESET;
      prev2_reg <= `RUSW_PREV_RESET;
    end else if (trigger && state_reg != RUSW_ST_FACTORY) begin
      prev1_reg <= {src_oh, ms_code, boot_reg};
      prev2_reg <= prev1_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      app_seen_reg <= 1'b0;
    end else if (fab_win) begin
      app_seen_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  assign wd_load   = {ctl_reg[`RUSW_CTL_TMR_HI:`RUSW_CTL_TMR_LO],
                      `RUSW_WD_LOW};
  assign wd_enable = (state_reg == RUSW_ST_APP_USER)
                     && ctl_reg[`RUSW_CTL_WATCHDOG_ENABLE_BIT];

  // Counts the control clock, whichever source feeds it
  rusw_watchdog #(
    .CNT_W (`RUSW_WD_W)
  ) u_wd (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .enable_i     (wd_enable),
    .reload_i     (strobe_qual[1]),
    .load_value_i (wd_load),
    .count_o      (wd_count),
    .expire_o     (wd_expire)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_timeout_o <= 1'b0;
    end else begin
      watchdog_timeout_o <= wd_expire;
    end
  end

  // ------------------------------------------------------------
  // Status views and shift register
  // ------------------------------------------------------------
  assign view_fac  = {ms_code, 6'h00, boot_reg};
  assign view_app1 = {ms_code, ctl_reg[`RUSW_CTL_WATCHDOG_ENABLE_BIT], wd_load};
  assign view_app2 = {ms_code, 6'h00, boot_reg};

  always_comb begin
    cap_next = `RUSW_INVALID_CAP;
    case (capture_sel_i)
      `RUSW_CAP_VIEW_A: begin
        cap_next = (state_reg == RUSW_ST_FACTORY)
          ? {7'h00, view_fac} : {7'h00, view_app1};
      end
      `RUSW_CAP_VIEW_B: begin
        cap_next = (state_reg == RUSW_ST_FACTORY)
          ? upd_reg : {7'h00, view_app2};
      end
      `RUSW_CAP_PREV1: begin
        cap_next = app_seen_reg
          ? {8'h00, prev1_reg} : `RUSW_INVALID_CAP;
      end
      `RUSW_CAP_PREV2: begin
        cap_next = app_seen_reg
          ? {8'h00, prev2_reg} : `RUSW_INVALID_CAP;
      end
      default: begin
        cap_next = `RUSW_INVALID_CAP;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (capture_i) begin
      shift_reg <= cap_next;
    end else if (shift_en_i) begin
      shift_reg <= {shift_data_i, shift_reg[`RUSW_CTL_W-1:1]};
    end
  end

  assign shift_data_o   = shift_reg[0];
  assign boot_address_o = boot_reg;
  assign master_state_o = ms_code;
  assign control_word_o = ctl_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_fab_load;
    trigger && fab_win |=> ctl_reg == $past(upd_reg)
      && state_reg == RUSW_ST_APP_LOAD;
  endproperty
  a_fab_load: assert property (p_fab_load)
    else $error("request did not load control from update");

  property p_err_clear;
    trigger && !fab_win |=> ctl_reg == `RUSW_CTL_RESET
      && state_reg == RUSW_ST_FACTORY;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error trigger did not clear control");

  property p_prio;
    external_config_reset_i |-> src_oh == 5'h10 && $onehot(src_oh);
  endproperty
  a_prio: assert property (p_prio)
    else $error("external reset lost priority");

  property p_record;
    trigger && state_reg != RUSW_ST_FACTORY
      |=> prev1_reg[23:0] == $past(boot_reg)
      && prev1_reg[25:24] == $past(ms_code)
      && prev1_reg[30:26] == $past(src_oh)
      && prev2_reg == $past(prev1_reg);
  endproperty
  a_record: assert property (p_record)
    else $error("previous-state record not captured");

  property p_fac_view;
    capture_i && capture_sel_i == `RUSW_CAP_VIEW_A
      && state_reg == RUSW_ST_FACTORY
      |=> shift_reg[31:30] == `RUSW_MS_FACTORY
      && shift_reg[29:24] == 6'h00
      && shift_reg[23:0] == $past(boot_reg);
  endproperty
  a_fac_view: assert property (p_fac_view)
    else $error("factory view layout wrong");

  property p_app_view;
    capture_i && capture_sel_i == `RUSW_CAP_VIEW_A
      && state_reg != RUSW_ST_FACTORY
      |=> shift_reg[28:0] == $past(wd_load)
      && shift_reg[29] == $past(ctl_reg[`RUSW_CTL_WATCHDOG_ENABLE_BIT]);
  endproperty
  a_app_view: assert property (p_app_view)
    else $error("application view layout wrong");

  property p_invalid;
    capture_i && capture_sel_i[1] && !app_seen_reg
      |=> shift_reg == `RUSW_INVALID_CAP;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("early record capture not flagged invalid");

  property p_no_upd;
    update_i && state_reg != RUSW_ST_FACTORY |=> $stable(upd_reg);
  endproperty
  a_no_upd: assert property (p_no_upd)
    else $error("update register written outside factory");

  property p_wd_off;
    state_reg != RUSW_ST_APP_USER |-> !wd_expire;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog expired outside user mode");

  property p_wd_expire;
    wd_expire |=> state_reg == RUSW_ST_FACTORY
      && prev1_reg[`RUSW_SRC_LO + `RUSW_SRC_WD] && watchdog_timeout_o;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog expiry not recorded");

  property p_qual;
    strobe_qual[0] |-> $past(strobe_sync[0], 4) && strobe_sync[0];
  endproperty
  a_qual: assert property (p_qual)
    else $error("request acted on before least pulse time");

  c_fab: cover property (trigger && fab_win);
  c_wd: cover property (wd_expire);
  c_invalid: cover property (capture_i && capture_sel_i[1]
                             && !app_seen_reg);
  c_user: cover property (state_reg == RUSW_ST_APP_USER && wd_enable);

endmodule

// *** tb/rusw_fabric_model.sv ***
// Fabric-side user logic: strobes and serial register access.
// Assumes the device samples on rising clk_sys_i edges.
`timescale 1ns/1ns

module rusw_fabric_model (
  // Clock and serial return
  input  wire logic       clk_sys_i,
  input  wire logic       sdo_i,
  // Strobes and shift controls
  output logic            request_o,
  output logic            reload_o,
  output logic            shift_en_o,
  output logic            sdi_o,
  output logic            capture_o,
  output logic            update_o,
  output logic [1:0]      sel_o
);
  initial begin
    request_o = 1'b0;
    reload_o = 1'b0;
    shift_en_o = 1'b0;
    sdi_o = 1'b0;
    capture_o = 1'b0;
    update_o = 1'b0;
    sel_o = 2'h0;
  end

  // ------------------------------------------------------------
  // Access tasks, entered just after a rising edge
  // ------------------------------------------------------------
  task automatic pulse(input logic rl);
    if (rl) begin
      reload_o = 1'b1;
    end else begin
      request_o = 1'b1;
    end
    repeat (10) @(posedge clk_sys_i);
    #1;
    request_o = 1'b0;
    reload_o = 1'b0;
  endtask

  task automatic read_word(input logic [1:0] sel, output logic [38:0] w);
    sel_o = sel;
    capture_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    capture_o = 1'b0;
    shift_en_o = 1'b1;
    for (int i = 0; i < 39; i++) begin
      @(negedge clk_sys_i);
      w[i] = sdo_i;
      @(posedge clk_sys_i);
      #1;
    end
    shift_en_o = 1'b0;
  endtask

  task automatic write_word(input logic [38:0] w);
    shift_en_o = 1'b1;
    for (int i = 0; i < 39; i++) begin
      sdi_o = w[i];
      @(posedge clk_sys_i);
      #1;
    end
    shift_en_o = 1'b0;
    sdi_o = ~sdi_o;
    update_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    update_o = 1'b0;
  endtask
endmodule

// *** tb/rusw_top_tb.sv ***
// Self-checking bench of the upgrade status and watchdog block.
// Assumes the fabric model is compiled before this file.
`timescale 1ns/1ns

module rusw_top_tb;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                ext = 1'b0;
  logic                pin_n = 1'b1;
  logic                crc = 1'b0;
  logic                user = 1'b0;
  logic                req, rld, sen, sdi, cap, upd, sdo, start, wdto;
  logic [1:0]          sel, ms;
  logic [23:0]         boot;
  rusw_pkg::rusw_ctl_t ctl;
  logic [38:0]         u, w, e, prev;
  int                  err_count = 0;
  int                  n_compared = 0;
  int                  seed = 49;
  int                  cyc = 0;
  int                  sb[5] = '{4, 2, 3, 1, 4};

  always #25 clk = ~clk;

  rusw_fabric_model fab (.clk_sys_i(clk), .sdo_i(sdo), .request_o(req),
    .reload_o(rld), .shift_en_o(sen), .sdi_o(sdi), .capture_o(cap),
    .update_o(upd), .sel_o(sel));

  rusw_top dut (.clk_sys_i(clk), .rst_i(rst), .external_config_reset_i(ext),
    .config_error_pin_n_i(pin_n), .crc_error_i(crc), .app_user_mode_i(user),
    .fabric_reconfig_request_i(req), .watchdog_reload_strobe_i(rld),
    .shift_en_i(sen), .shift_data_i(sdi), .capture_i(cap), .update_i(upd),
    .capture_sel_i(sel), .shift_data_o(sdo), .reconfig_start_o(start),
    .boot_address_o(boot), .master_state_o(ms),
    .watchdog_timeout_o(wdto), .control_word_o(ctl));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [38:0] rec(input int s, input logic [1:0] m,
                                      input logic [38:0] c);
    return {8'h00, 5'(1 << s), m, c[33:12], 2'b00};
  endfunction

  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [38:0] x,
                       input logic [38:0] g);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wait_pulse(input logic wd, input string nm);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(negedge clk);
      seen = wd ? (wdto === 1'b1) : (start === 1'b1);
    end
    check(nm, 39'h1, {38'h0, seen});
    @(posedge clk);
    #1;
  endtask

  task automatic boot_app(input logic go_user);
    fab.write_word(u);
    fab.read_word(2'h1, w);
    check("update view", u, w);
    fork
      fab.pulse(1'b0);
      wait_pulse(1'b0, "start");
    join
    check("control", u, ctl);
    check("boot", {15'h0, u[33:12], 2'b00}, {15'h0, boot});
    check("load state", 39'h1, {37'h0, ms});
    user = go_user;
    @(posedge clk);
    #1;
    if (go_user) check("user state", 39'h3, {37'h0, ms});
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check("reset state", 39'h0, {37'h0, ms});
    fab.read_word(2'h0, w);
    check("factory view", 39'h0, w);
    fab.read_word(2'h2, w);
    check("early rec1", 39'h7F_FFFF_FFFF, w);
    fab.read_word(2'h3, w);
    check("early rec2", 39'h7F_FFFF_FFFF, w);
    for (int k = 0; k < 5; k++) begin
      u = 39'({$random(seed), $random(seed)});
      u[35] = (k == 3);
      if (k == 3) u[11:0] = 12'h000;
      boot_app(k != 2);
      if (k == 0) begin
        fab.read_word(2'h0, w);
        check("view a", {9'h3, u[35], u[11:0], 17'h8}, w);
        fab.read_word(2'h1, w);
        check("view b", {9'h3, 6'h00, u[33:12], 2'b00}, w);
        fab.pulse(1'b0);
        fab.pulse(1'b1);
        check("held state", 39'h3, {37'h0, ms});
      end
      if (k == 4) fab.write_word(~u);
      if (k == 3) begin
        fab.pulse(1'b1);
        check("reloaded state", 39'h3, {37'h0, ms});
        wait_pulse(1'b1, "timeout");
      end
      ext = (k == 0 || k == 4);
      pin_n = !(k == 1 || k == 4);
      crc = (k == 2);
      @(posedge clk);
      #1;
      ext = 1'b0;
      pin_n = 1'b1;
      crc = 1'b0;
      user = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("error state", 39'h0, {37'h0, ms});
      check("cleared control", 39'h0, ctl);
      e = rec(sb[k], (k == 2) ? 2'h1 : 2'h3, u);
      fab.read_word(2'h2, w);
      check("rec1", e, w);
      fab.read_word(2'h3, w);
      if (k > 0) check("rec2", prev, w);
      prev = e;
    end
    fab.read_word(2'h1, w);
    check("kept update", u, w);
    complete_run();
  end
endmodule
